//--- shared/flash_cmd_pkg.sv
package flash_cmd_pkg;

  // Opcodes
  localparam logic [7:0] OP_SEC_READ = 8'h48;
  localparam logic [7:0] OP_RESET_EN = 8'h66;
  localparam logic [7:0] OP_RESET    = 8'h99;
  localparam logic [7:0] OP_SFDP     = 8'h5A;

  // Frame field lengths in bits
  localparam int OPC_BITS  = 8;
  localparam int ADDR_BITS = 24;
  localparam int BYTE_BITS = 8;
  localparam int HDR_BITS  = OPC_BITS + ADDR_BITS + BYTE_BITS;

  // Security register address fields
  localparam int         SEC_OFS_BITS = 9;
  localparam int         SEC_SEL_LSB  = 12;
  localparam int         SEC_GAP_LSB  = 9;
  localparam int         SEC_TOP_LSB  = 16;
  localparam logic [7:0] SEC_TOP      = 8'h00;
  localparam logic [3:0] SEC_SEL_LO   = 4'h1;
  localparam logic [3:0] SEC_SEL_HI   = 4'h3;
  localparam logic [2:0] SEC_GAP      = 3'h0;
  localparam int         SEC_IDX_BITS = 2;
  localparam logic [7:0] NO_DATA      = 8'hFF;

  // Discoverable-parameter header, byte 00H in the low bits
  localparam int          SFDP_BYTES    = 24;
  localparam logic [4:0]  SFDP_MAKER    = 5'h10;
  localparam logic [31:0] SFDP_SIG      = 32'h5044_4653;
  localparam logic [7:0]  SFDP_MINOR    = 8'h00;
  localparam logic [7:0]  SFDP_MAJOR    = 8'h01;
  localparam logic [7:0]  SFDP_NHDR     = 8'h01;
  localparam logic [7:0]  SFDP_UNUSED   = 8'hFF;
  localparam logic [7:0]  SFDP_STD_ID   = 8'h00;
  localparam logic [7:0]  SFDP_STD_LEN  = 8'h09;
  localparam logic [23:0] SFDP_STD_PTR  = 24'h00_0030;
  localparam logic [7:0]  SFDP_VND_LEN  = 8'h03;
  localparam logic [23:0] SFDP_VND_PTR  = 24'h00_0060;
  localparam logic [8*SFDP_BYTES-1:0] SFDP_HDR = {
    SFDP_UNUSED, SFDP_VND_PTR, SFDP_VND_LEN, SFDP_MAJOR, SFDP_MINOR,
    SFDP_UNUSED,
    SFDP_UNUSED, SFDP_STD_PTR, SFDP_STD_LEN, SFDP_MAJOR, SFDP_MINOR,
    SFDP_STD_ID,
    SFDP_UNUSED, SFDP_NHDR, SFDP_MAJOR, SFDP_MINOR, SFDP_SIG};

  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int RST_TIME_NS   = 30000;

  // Volatile settings lost on reset
  typedef struct packed {
    logic [7:0] volatileStatus;
    logic       writeEnableLatch;
    logic       suspendFlag;
    logic       deepPowerDown;
    logic [7:0] readParameterBits;
    logic [7:0] continuousReadModeBits;
    logic [2:0] wrapSettingBits;
  } volatile_t;

endpackage : flash_cmd_pkg

//--- shared/flash_bus_if.sv
`timescale 1ns/1ps
interface flash_bus_if;
  logic sclk;
  logic csN;
  logic si;
  logic so;
  logic soOe_n;
  modport dev  (input sclk, csN, si, output so, soOe_n);
  modport host (output sclk, csN, si, input so, soOe_n);
endinterface : flash_bus_if

//--- hw/flash_dev.sv
`timescale 1ns/1ps
module flash_dev #(
  parameter int         RST_TIME_NS = flash_cmd_pkg::RST_TIME_NS,
  parameter logic [7:0] MAKER_ID    = 8'hA5  // Arbitrary value
) (
  // System clock and reset
  input  wire logic                clk,
  input  wire logic                reset_n,
  // Serial link
  flash_bus_if.dev                 bus,
  // Volatile settings, clk domain
  input  wire logic                volWr,
  input  flash_cmd_pkg::volatile_t volIn,
  output flash_cmd_pkg::volatile_t vol,
  output logic                     rstBusy,
  output logic                     abortOp,
  // Security register storage, link domain
  output logic [10:0]              secAddr,
  input  wire logic [7:0]          secData
);

  localparam int RST_CYC =
    (RST_TIME_NS + flash_cmd_pkg::CLK_PERIOD_NS - 1) /
    flash_cmd_pkg::CLK_PERIOD_NS;
  localparam int TW = $clog2(RST_CYC + 1);

  typedef enum logic [2:0] {
    F_CMD, F_ADDR, F_DUMMY, F_DATA, F_IGNORE
  } fstate_t;

  // Per-frame state, cleared while chip select is high
  typedef struct packed {
    fstate_t     st;
    logic [4:0]  cnt;
    logic [7:0]  op;
    logic [23:0] addr;
    logic [7:0]  tx;
  } frame_t;

  // Link state that lives across frames
  typedef struct packed {
    logic armed;
    logic rstTgl;
    logic busyS1;
    logic busyS2;
  } link_t;

  // System clock state
  typedef struct packed {
    logic            tglS1;
    logic            tglS2;
    logic            tglPrev;
    logic            busy;
    logic [TW-1:0]   timer;
    flash_cmd_pkg::volatile_t vol;
    logic            abortOp;
  } core_t;

  frame_t frame_ff, nxt_frame;
  link_t  link_ff, nxt_link;
  core_t  core_ff, nxt_core;
  logic [1:0] lrst_ff;
  logic       so_ff;
  logic       soOe_n_ff;

  logic [7:0] opcNow;
  logic [7:0] loadByte;
  logic [3:0] secSel;
  logic       secOk;

  //////////////////////////////////////////////////////////////////////
  // Address decode and byte source

  // Byte from the fixed header, FFH beyond it
  function automatic logic [7:0] sfdpByte(input logic [23:0] a);
    logic [7:0] b;
    b = flash_cmd_pkg::SFDP_UNUSED;
    if (a < 24'(flash_cmd_pkg::SFDP_BYTES)) begin
      b = flash_cmd_pkg::SFDP_HDR[8*a[4:0] +: 8];
      if (a[4:0] == flash_cmd_pkg::SFDP_MAKER) begin
        b = MAKER_ID;
      end
    end
    return b;
  endfunction : sfdpByte

  // Register select decode
  always_comb begin
    secSel = frame_ff.addr[flash_cmd_pkg::SEC_SEL_LSB +: 4];
    secOk  = (frame_ff.addr[flash_cmd_pkg::SEC_TOP_LSB +: 8]
              == flash_cmd_pkg::SEC_TOP)
          && (frame_ff.addr[flash_cmd_pkg::SEC_GAP_LSB +: 3]
              == flash_cmd_pkg::SEC_GAP)
          && (secSel >= flash_cmd_pkg::SEC_SEL_LO)
          && (secSel <= flash_cmd_pkg::SEC_SEL_HI);
    secAddr = {2'(secSel - flash_cmd_pkg::SEC_SEL_LO),
               frame_ff.addr[flash_cmd_pkg::SEC_OFS_BITS-1:0]};
    if (frame_ff.op == flash_cmd_pkg::OP_SFDP) begin
      loadByte = sfdpByte(frame_ff.addr);
    end else if (secOk) begin
      loadByte = secData;
    end else begin
      loadByte = flash_cmd_pkg::NO_DATA;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Link side command decoder

  // Next frame and link state
  always_comb begin
    nxt_frame = frame_ff;
    nxt_link  = link_ff;
    nxt_link.busyS1 = core_ff.busy;
    nxt_link.busyS2 = link_ff.busyS1;
    opcNow = {frame_ff.op[6:0], bus.si};
    nxt_frame.cnt = 5'(frame_ff.cnt + 1'b1);
    unique case (frame_ff.st)
      F_CMD: begin
        nxt_frame.op = opcNow;
        if (frame_ff.cnt == 5'(flash_cmd_pkg::OPC_BITS - 1)) begin
          nxt_frame.cnt = '0;
          nxt_frame.st  = F_IGNORE;
          nxt_link.armed = 1'b0;
          if (!link_ff.busyS2) begin
            nxt_link.armed = (opcNow == flash_cmd_pkg::OP_RESET_EN);
            if (opcNow == flash_cmd_pkg::OP_SEC_READ ||
                opcNow == flash_cmd_pkg::OP_SFDP) begin
              nxt_frame.st = F_ADDR;
            end
            if (opcNow == flash_cmd_pkg::OP_RESET && link_ff.armed) begin
              nxt_link.rstTgl = ~link_ff.rstTgl;
            end
          end
        end
      end
      F_ADDR: begin
        nxt_frame.addr = {frame_ff.addr[22:0], bus.si};
        if (frame_ff.cnt == 5'(flash_cmd_pkg::ADDR_BITS - 1)) begin
          nxt_frame.cnt = '0;
          nxt_frame.st  = F_DUMMY;
        end
      end
      F_DUMMY, F_DATA: begin
        if (frame_ff.cnt[2:0] == 3'(flash_cmd_pkg::BYTE_BITS - 1)) begin
          nxt_frame.cnt = '0;
          nxt_frame.st  = F_DATA;
          nxt_frame.tx  = loadByte;
          if (frame_ff.op == flash_cmd_pkg::OP_SFDP) begin
            nxt_frame.addr = 24'(frame_ff.addr + 1'b1);
          end else begin
            nxt_frame.addr[flash_cmd_pkg::SEC_OFS_BITS-1:0] =
              9'(frame_ff.addr[flash_cmd_pkg::SEC_OFS_BITS-1:0]
                 + 1'b1);
          end
        end
      end
      F_IGNORE: begin
        nxt_frame.cnt  = frame_ff.cnt;
        nxt_link.armed = 1'b0;
      end
    endcase
  end

  // Link reset applied at once, as the serial clock idles in reset
  always_ff @(posedge bus.sclk or negedge reset_n) begin
    if (!reset_n) begin
      lrst_ff <= '0;
    end else begin
      lrst_ff <= {lrst_ff[0], 1'b1};
    end
  end

  // Frame state, cleared by chip select high
  always_ff @(posedge bus.sclk or posedge bus.csN) begin
    if (bus.csN) begin
      frame_ff <= '{st: F_CMD, default: '0};
    end else begin
      frame_ff <= nxt_frame;
    end
  end

  // State kept across frames, released on a serial clock edge
  always_ff @(posedge bus.sclk or negedge lrst_ff[1]) begin
    if (!lrst_ff[1]) begin
      link_ff <= '0;
    end else begin
      link_ff <= nxt_link;
    end
  end

  // Serial output, changed on the falling edge
  always_ff @(negedge bus.sclk or posedge bus.csN) begin
    if (bus.csN) begin
      so_ff     <= 1'b0;
      soOe_n_ff <= 1'b1;
    end else begin
      so_ff     <= frame_ff.tx[3'(flash_cmd_pkg::BYTE_BITS - 1)
                               - frame_ff.cnt[2:0]];
      soOe_n_ff <= (frame_ff.st != F_DATA);
    end
  end

  assign bus.so     = so_ff;
  assign bus.soOe_n = soOe_n_ff;

  //////////////////////////////////////////////////////////////////////
  // System clock side: reset recovery and volatile settings

  // Next core state
  always_comb begin
    nxt_core = core_ff;
    nxt_core.tglS1   = link_ff.rstTgl;
    nxt_core.tglS2   = core_ff.tglS1;
    nxt_core.tglPrev = core_ff.tglS2;
    nxt_core.abortOp = 1'b0;
    if (core_ff.timer != '0) begin
      nxt_core.timer = TW'(core_ff.timer - 1'b1);
    end else begin
      nxt_core.busy = 1'b0;
    end
    if (core_ff.tglS2 != core_ff.tglPrev) begin
      nxt_core.timer   = TW'(RST_CYC - 1);
      nxt_core.busy    = 1'b1;
      nxt_core.abortOp = 1'b1;
      nxt_core.vol     = '0;
    end else if (volWr && !core_ff.busy) begin
      nxt_core.vol = volIn;
    end
  end

  // Core register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      core_ff <= '0;
    end else begin
      core_ff <= nxt_core;
    end
  end

  assign vol     = core_ff.vol;
  assign rstBusy = core_ff.busy;
  assign abortOp = core_ff.abortOp;

endmodule : flash_dev

//--- hw/flash_host.sv
`timescale 1ns/1ps
module flash_host #(
  parameter int HALF = 2   // System clocks per serial half period, >= 2
) (
  // System clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Serial link
  flash_bus_if.host        bus,
  // Command request
  input  wire logic        start,
  input  wire logic [7:0]  opcode,
  input  wire logic [23:0] addr,
  input  wire logic        withAddr,
  input  wire logic [15:0] readLen,
  // Status and read data
  output logic             busy,
  output logic             done,
  output logic [7:0]       rdData,
  output logic             rdValid
);

  typedef enum logic [1:0] {H_IDLE, H_LEAD, H_SHIFT, H_TRAIL} hstate_t;

  typedef struct packed {
    hstate_t     st;
    logic [7:0]  cnt;
    logic        sclk;
    logic        csN;
    logic        si;
    logic [39:0] tx;
    logic [5:0]  txLeft;
    logic [15:0] rxBytes;
    logic [2:0]  rxBit;
    logic [7:0]  rxSh;
    logic        soS1;
    logic        soS2;
    logic        oeS1;
    logic        oeS2;
    logic [7:0]  rdData;
    logic        rdValid;
    logic        done;
  } host_t;

  host_t s_ff, nxt_s;

  //////////////////////////////////////////////////////////////////////
  // Frame sequencer

  // Next host state
  always_comb begin
    nxt_s = s_ff;
    nxt_s.soS1    = bus.so;
    nxt_s.soS2    = s_ff.soS1;
    nxt_s.oeS1    = bus.soOe_n;   // Released line reads high
    nxt_s.oeS2    = s_ff.oeS1;
    nxt_s.rdValid = 1'b0;
    nxt_s.done    = 1'b0;
    nxt_s.cnt     = 8'(s_ff.cnt + 1'b1);
    unique case (s_ff.st)
      H_IDLE: begin
        nxt_s.cnt = '0;
        if (start) begin
          nxt_s.st      = H_LEAD;
          nxt_s.csN     = 1'b0;
          nxt_s.tx      = {opcode, addr, 8'h00};
          nxt_s.txLeft  = withAddr ? 6'(flash_cmd_pkg::HDR_BITS)
                                   : 6'(flash_cmd_pkg::OPC_BITS);
          nxt_s.rxBytes = readLen;
          nxt_s.rxBit   = '0;
          nxt_s.si      = opcode[7];
        end
      end
      H_LEAD: begin
        if (s_ff.cnt == 8'(HALF - 1)) begin
          nxt_s.st  = H_SHIFT;
          nxt_s.cnt = '0;
        end
      end
      H_SHIFT: begin
        if (s_ff.cnt == 8'(HALF - 1)) begin
          nxt_s.sclk = 1'b1;
        end
        if (s_ff.cnt == 8'(2 * HALF - 1)) begin
          nxt_s.sclk = 1'b0;
          nxt_s.cnt  = '0;
          if (s_ff.txLeft > 6'd1) begin
            nxt_s.tx     = {s_ff.tx[38:0], 1'b0};
            nxt_s.si     = s_ff.tx[38];
            nxt_s.txLeft = 6'(s_ff.txLeft - 1'b1);
          end else if (s_ff.txLeft == 6'd1) begin
            nxt_s.txLeft = '0;
            nxt_s.si     = 1'b0;
            if (s_ff.rxBytes == '0) begin
              nxt_s.st = H_TRAIL;
            end
          end else begin
            nxt_s.rxSh  = {s_ff.rxSh[6:0], s_ff.soS2 | s_ff.oeS2};
            nxt_s.rxBit = 3'(s_ff.rxBit + 1'b1);
            if (s_ff.rxBit == 3'(flash_cmd_pkg::BYTE_BITS - 1)) begin
              nxt_s.rdData  = {s_ff.rxSh[6:0], s_ff.soS2 | s_ff.oeS2};
              nxt_s.rdValid = 1'b1;
              nxt_s.rxBytes = 16'(s_ff.rxBytes - 1'b1);
              if (s_ff.rxBytes == 16'd1) begin
                nxt_s.st = H_TRAIL;
              end
            end
          end
        end
      end
      H_TRAIL: begin
        nxt_s.csN = 1'b1;
        if (s_ff.cnt == 8'(2 * HALF - 1)) begin
          nxt_s.st   = H_IDLE;
          nxt_s.done = 1'b1;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_ff <= '{st: H_IDLE, csN: 1'b1, default: '0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign bus.sclk = s_ff.sclk;
  assign bus.csN  = s_ff.csN;
  assign bus.si   = s_ff.si;
  assign busy     = (s_ff.st != H_IDLE);
  assign done     = s_ff.done;
  assign rdData   = s_ff.rdData;
  assign rdValid  = s_ff.rdValid;

endmodule : flash_host

//--- verification/flash_link_properties.sv
`timescale 1ns/1ps
module flash_link_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Serial link
  input wire logic sclk,
  input wire logic csN,
  input wire logic si,
  input wire logic so,
  input wire logic soOe_n
);
  logic [15:0] riseCnt_ff;
  logic        sclk_ff;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////
  // Serial rising edges seen in a frame
  always_ff @(posedge clk) begin
    sclk_ff <= sclk;
    if (!reset_n || csN) begin
      riseCnt_ff <= 16'h0000;
    end else if (sclk && !sclk_ff) begin
      riseCnt_ff <= riseCnt_ff + 16'h0001;
    end
  end

  ////////////////////////////////////////
  a_cs_fall_idle: assert property ($fell(csN) |-> !sclk)
    else $error("select fell with clock high");
  a_si_held_rise: assert property ($rose(sclk) |-> $stable(si))
    else $error("input data moved at rising edge");
  a_sclk_half: assert property ($rose(sclk) |=> sclk ##1 !sclk)
    else $error("serial clock high time wrong");
  a_so_on_fall: assert property (
    !soOe_n && !$past(soOe_n) && $changed(so) |-> $fell(sclk))
    else $error("output changed off falling edge");
  a_out_after_hdr: assert property (
    $fell(soOe_n) |-> riseCnt_ff == 16'h0028)
    else $error("output began at wrong bit count");
  a_no_out_early: assert property (
    !csN && riseCnt_ff < 16'h0028 |-> soOe_n)
    else $error("output driven during header");
  a_idle_released: assert property (csN |-> soOe_n && !sclk)
    else $error("output driven while deselected");
  a_whole_bytes: assert property (
    $rose(csN) |-> riseCnt_ff[2:0] == 3'h0)
    else $error("frame not whole bytes");
endmodule : flash_link_properties

//--- verification/flash_secreg_reset_sfdp_cmds_test.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin nTests++; if ((g) !== (e)) begin fails++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module flash_secreg_reset_sfdp_cmds_test;
  localparam int         RST_NS  = 10000;
  localparam int         RST_CYC = 400;     // RST_NS over 25 ns
  localparam logic [7:0] MAKER   = 8'h3C;   // Arbitrary value
  logic        clk = 1'b0, reset_n, start = 1'b0, withAddr = 1'b0;
  logic        volWr = 1'b0, busy, done, rdValid, rstBusy, abortOp;
  logic [7:0]  opcode = 8'h00, rdData;
  logic [23:0] addr = 24'h00_0000;
  logic [15:0] readLen = 16'h0000;
  logic [29:0] v;
  logic [1:0]  idx;
  logic [10:0] secAddr;
  logic [7:0]  secData, expQ[$];
  flash_cmd_pkg::volatile_t volIn = '0, vol;
  int fails = 0, nTests = 0, nDrive = 0, nAbort = 0, busyCyc = 0, cyc = 0;
  int d0;
  logic [23:0] badA[4] = '{24'h00_0000, 24'h00_4000, 24'h00_1200,
                           24'h01_1000};
  logic [7:0] hdr[26] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01,
    8'hFF, 8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hFF, MAKER,
    8'h00, 8'h01, 8'h03, 8'h60, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF};

  flash_bus_if flash_bus_if_inst ();
  flash_dev #(.RST_TIME_NS(RST_NS), .MAKER_ID(MAKER)) flash_dev_inst (
    .clk(clk), .reset_n(reset_n), .bus(flash_bus_if_inst), .volWr(volWr),
    .volIn(volIn), .vol(vol), .rstBusy(rstBusy), .abortOp(abortOp),
    .secAddr(secAddr), .secData(secData));
  flash_host #(.HALF(2)) flash_host_inst (
    .clk(clk), .reset_n(reset_n), .bus(flash_bus_if_inst), .start(start),
    .opcode(opcode), .addr(addr), .withAddr(withAddr), .readLen(readLen),
    .busy(busy), .done(done), .rdData(rdData), .rdValid(rdValid));
  flash_link_properties flash_link_properties_inst (
    .clk(clk), .reset_n(reset_n), .sclk(flash_bus_if_inst.sclk),
    .csN(flash_bus_if_inst.csN), .si(flash_bus_if_inst.si),
    .so(flash_bus_if_inst.so), .soOe_n(flash_bus_if_inst.soOe_n));

  ////////////////////////////////////////
  // Clock and security memory
  always #12.5 clk = ~clk;
  assign secData = secAddr[7:0] ^ {secAddr[10:8], 5'h00};
  always @(negedge flash_bus_if_inst.soOe_n) nDrive++;

  // Compare each byte with the oldest note, count pulses
  always @(negedge clk) begin
    cyc++;
    if (rstBusy === 1'b1) busyCyc++;
    if (abortOp === 1'b1) nAbort++;
    if (rdValid === 1'b1) begin
      `CHK("rdData", expQ.size() ? expQ[0] : 8'hxx, rdData)
      if (expQ.size() != 0) void'(expQ.pop_front());
    end
    if (cyc > 20000) begin
      fails++;
      final_report();
    end
  end

  ////////////////////////////////////////
  task automatic frame(input logic [7:0] op, input logic [23:0] a,
                       input logic wa, input logic [15:0] n);
    @(posedge clk);
    start    <= 1'b1;
    opcode   <= op;
    addr     <= a;
    withAddr <= wa;
    readLen  <= n;
    @(posedge clk);
    start <= 1'b0;
    repeat (8000) begin
      @(negedge clk);
      if (done === 1'b1) break;
    end
  endtask : frame

  task automatic secRead(input logic [1:0] i, input logic [8:0] ofs,
                         input logic [15:0] n);
    logic [8:0] o;
    o = ofs;
    repeat (n) begin
      expQ.push_back(o[7:0] ^ {i, o[8], 5'h00});
      o = o + 9'h001;
    end
    frame(8'h48, {8'h00, 2'b00, i + 2'b01, 3'h0, ofs}, 1'b1, n);
  endtask : secRead

  task automatic loadVol(input logic [29:0] x);
    @(posedge clk);
    volWr <= 1'b1;
    volIn <= x;
    @(posedge clk);
    volWr <= 1'b0;
  endtask : loadVol

  task automatic endTest(input string nm);
    `CHK("queue", 0, expQ.size())
    `CHK("busy", 1'b0, busy)
    $display("test %s done", nm);
  endtask : endTest

  task automatic final_report();
    $display("checks %0d mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  ////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(99815));
    reset_n <= 1'b0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    idx = 2'($urandom % 3);
    secRead(idx, 9'h1FD, 16'h0005);
    secRead(2'($urandom % 3), 9'($urandom), 16'h0003);
    endTest("secread");
    foreach (badA[i]) begin
      expQ.push_back(8'hFF);
      frame(8'h48, badA[i], 1'b1, 16'h0001);
    end
    endTest("reserved");
    foreach (hdr[i]) expQ.push_back(hdr[i]);
    frame(8'h5A, 24'h00_0000, 1'b1, 16'h001A);
    endTest("table");
    // Lone and broken reset pairs leave settings alone
    v = 30'($urandom | 32'h0000_0001);
    loadVol(v);
    frame(8'h99, 24'h00_0000, 1'b0, 16'h0000);
    frame(8'h66, 24'h00_0000, 1'b0, 16'h0000);
    secRead(idx, 9'h000, 16'h0001);
    frame(8'h99, 24'h00_0000, 1'b0, 16'h0000);
    `CHK("vol", v, vol)
    `CHK("aborts", 0, nAbort)
    `CHK("rstBusy", 1'b0, rstBusy)
    // Proper pair, then commands during recovery
    frame(8'h66, 24'h00_0000, 1'b0, 16'h0000);
    frame(8'h99, 24'h00_0000, 1'b0, 16'h0000);
    repeat (4) @(negedge clk);
    `CHK("vol", 30'h0000_0000, vol)
    `CHK("rstBusy", 1'b1, rstBusy)
    loadVol(v);
    @(negedge clk);
    `CHK("vol", 30'h0000_0000, vol)
    d0 = nDrive;
    expQ.push_back(8'hFF);
    frame(8'h48, 24'h00_1000, 1'b1, 16'h0001);
    `CHK("drive", d0, nDrive)
    repeat (1000) begin
      @(negedge clk);
      if (rstBusy === 1'b0) break;
    end
    `CHK("recovery", RST_CYC, busyCyc)
    `CHK("aborts", 1, nAbort)
    secRead(idx, 9'h0AA, 16'h0002);
    endTest("resetpair");
    final_report();
  end
endmodule : flash_secreg_reset_sfdp_cmds_test
